/* hw/dma_engine.sv */
// Purpose: Fourteen-channel DMA engine with byte-wide boot load.
// Assumes: Control blocks arrive on a load port; data moves through
//          a source stream, a buffer and a destination stream.
// Notes: Channels 0-3 external, 4-7 link transmit, 8-11 link receive,
//        12-13 slave-initiated. Byte space writes are not modelled.
// How it works
// - Fourteen independent channels, no core per-word involvement
// - Runs alongside core, never stalls it
// - Four external channels, master or handshake mode
// - Eight link channels, quad words, handshake only
// - Link receive priority rotates among four
// - Two slave channels, slave protocol only
// - Flyby only on channel 0, device to SDRAM
// - Flyby releases data bus, drives strobes, waits ack
// - Finished block can start a chained block
// - Two-dimensional index, count, modify addressing
// - Boot loads bytes, packs four per word, channel 0
// - Each boot byte read waits sixteen cycles
// - Boot select pin is the EPROM chip select
// - Byte space, twenty-four address bits, unmapped
// - After boot, byte space only through DMA
// - Link data buffered as quad-word units
// - External, link and slave routes all supported
// - Buffer transfers paced at half core rate
`timescale 1ns/1ps
module dma_engine #(
    parameter int BOOT_WORDS = 256,    // Words loaded at boot
    parameter int FIFO_DEPTH = 16,
    parameter int DW = 32
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic boot_eprom_mode_i,
    input wire logic cb_wr_i,
    input wire logic [dma_pkg::CHW-1:0] cb_chan_i,
    input wire logic [31:0] cb_index_i,
    input wire logic [15:0] cb_xcount_i,
    input wire logic [31:0] cb_xmod_i,
    input wire logic [15:0] cb_ycount_i,
    input wire logic [31:0] cb_ymod_i,
    input wire logic [dma_pkg::CTRL_W-1:0] cb_ctrl_i,
    input wire logic [dma_pkg::CHW-1:0] cb_next_i,
    input wire logic [dma_pkg::NCH-1:0] chan_req_i,
    output logic [dma_pkg::NCH-1:0] chan_busy_o,
    output logic [dma_pkg::NCH-1:0] chan_done_o,
    output logic xfer_valid_o,
    output logic [dma_pkg::CHW-1:0] xfer_chan_o,
    output logic [31:0] xfer_addr_o,
    output logic xfer_last_o,
    input wire logic [DW-1:0] src_data_i,
    input wire logic src_valid_i,
    output logic src_ready_o,
    output logic [DW-1:0] dst_data_o,
    output logic dst_valid_o,
    input wire logic dst_ready_i,
    output logic [dma_pkg::EP_AW-1:0] eprom_addr_o,
    input wire logic [7:0] eprom_byte_i,
    output logic boot_eprom_select_n_o,
    output logic booting_o,
    output logic [31:0] ext_addr_o,
    output logic [3:0] sdram_bank_selects_n_o,
    output logic io_read_strobe_n_o,
    output logic io_write_strobe_n_o,
    output logic io_transceiver_enable_n_o,
    output logic rd_wr_n_o,
    output logic ext_data_oe_o,
    input wire logic ack_i
);
    localparam int NCH = dma_pkg::NCH;
    localparam int CHW = dma_pkg::CHW;
    localparam logic [dma_pkg::EP_AW-1:0] BOOT_LAST =
        dma_pkg::EP_AW'(BOOT_WORDS * dma_pkg::BYTES_W - 1);

    // Per-channel control block state
    logic [31:0] idx_q [NCH];          // Current address
    logic [31:0] xmod_q [NCH];         // Step inside a row
    logic [31:0] ymod_q [NCH];         // Step at row end
    logic [15:0] xlen_q [NCH];         // Row length for reload
    logic [15:0] xcnt_q [NCH];         // Words left in row
    logic [15:0] ycnt_q [NCH];         // Rows left
    logic [dma_pkg::CTRL_W-1:0] ctrl_q [NCH];
    logic [CHW-1:0] next_q [NCH];      // Chain target
    logic [NCH-1:0] loaded_q;          // Block present
    logic [NCH-1:0] active_q;          // Block running

    dma_pkg::eng_state_e st_q;
    logic [CHW-1:0] cur_q;             // Channel being served
    logic [1:0] beat_q;                // Word within a link quad
    logic [$clog2(dma_pkg::SOC_DIV)-1:0] div_q;
    logic soc_en;                      // Half-rate pacing pulse
    logic [4:0] wait_q;                // Byte read wait counter
    logic [1:0] byte_q;                // Byte position in word
    logic [23:0] pack_q;               // Bytes gathered so far
    logic [dma_pkg::EP_AW-1:0] boot_addr_q;
    logic [DW-1:0] pack_word;

    // Step results for the served channel
    logic [31:0] n_idx;
    logic [15:0] n_x;
    logic [15:0] n_y;
    logic last;
    logic step;

    // Eligibility and arbitration
    logic [NCH-1:0] elig;
    logic [dma_pkg::LRX_N-1:0] rx_grant;
    logic [CHW-1:0] pick;
    logic pick_ok;

    // Buffer signals
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [DW-1:0] fifo_in_data;
    logic ep_sample;
    logic ep_push;
    logic ep_path;

    // Divider: one pulse every SOC_DIV clocks paces buffer traffic
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign soc_en = (div_q == '0);

    // Which channels may be served now
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            if (c <= dma_pkg::EXT_LAST) begin
                // Master mode runs freely, handshake waits for request
                elig[c] = active_q[c] & (ctrl_q[c][dma_pkg::C_MASTER]
                    | chan_req_i[c]);
            end else begin
                // Link and slave channels wait for the far side
                elig[c] = active_q[c] & chan_req_i[c];
            end
        end
    end

    // Rotating pick inside the link receive group
    dma_rr_arbiter #(
        .N(dma_pkg::LRX_N)
    ) u_rx_arb (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .req_i(elig[dma_pkg::LRX_FIRST +: dma_pkg::LRX_N]),
        .advance_i(st_q == dma_pkg::S_IDLE && soc_en),
        .grant_o(rx_grant)
    );

    // Receive group first, then lowest numbered eligible channel
    always_comb begin
        pick = '0;
        pick_ok = 1'b0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (elig[c]) begin
                pick = CHW'(c);
                pick_ok = 1'b1;
            end
        end
        for (int k = 0; k < dma_pkg::LRX_N; k++) begin
            if (rx_grant[k]) begin
                pick = CHW'(dma_pkg::LRX_FIRST + k);
                pick_ok = 1'b1;
            end
        end
    end

    // Next address and counts for the served channel
    always_comb begin
        last = 1'b0;
        n_idx = idx_q[cur_q] + xmod_q[cur_q];
        n_x = xcnt_q[cur_q] - dma_pkg::CNT_ONE;
        n_y = ycnt_q[cur_q];
        if (xcnt_q[cur_q] <= dma_pkg::CNT_ONE) begin
            if (ctrl_q[cur_q][dma_pkg::C_2D]
                && ycnt_q[cur_q] > dma_pkg::CNT_ONE) begin
                // Row done: jump by the row stride, reload row count
                n_idx = idx_q[cur_q] + ymod_q[cur_q];
                n_x = xlen_q[cur_q];
                n_y = ycnt_q[cur_q] - dma_pkg::CNT_ONE;
            end else begin
                last = 1'b1;
            end
        end
    end

    // Byte path: boot, or channel 0 byte space access
    assign ep_path = (st_q == dma_pkg::S_BOOT) || (st_q == dma_pkg::S_EP);
    assign ep_sample = ep_path && wait_q == 5'(dma_pkg::EP_WAIT - 1);
    assign ep_push = ep_sample && (byte_q == 2'(dma_pkg::BYTES_W - 1)
        || (st_q == dma_pkg::S_EP && last));
    assign pack_word = {eprom_byte_i, pack_q} >> (8 * (3 - byte_q));

    // A served word advances its channel
    always_comb begin
        step = 1'b0;
        unique case (st_q)
            dma_pkg::S_XFER: step = soc_en & fifo_in_ready;
            dma_pkg::S_FLY: step = ack_i;
            dma_pkg::S_EP: step = ep_sample & (fifo_in_ready | ~ep_push);
            dma_pkg::S_BOOT, dma_pkg::S_IDLE: step = 1'b0;
        endcase
    end

    // Control block load and per-channel address walk
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            loaded_q <= '0;
            active_q <= '0;
            for (int c = 0; c < NCH; c++) begin
                idx_q[c] <= '0;
                xmod_q[c] <= '0;
                ymod_q[c] <= '0;
                xlen_q[c] <= '0;
                xcnt_q[c] <= '0;
                ycnt_q[c] <= '0;
                ctrl_q[c] <= '0;
                next_q[c] <= '0;
            end
        end else begin
            if (step) begin
                idx_q[cur_q] <= n_idx;
                xcnt_q[cur_q] <= n_x;
                ycnt_q[cur_q] <= n_y;
                if (last) begin
                    active_q[cur_q] <= 1'b0;
                    loaded_q[cur_q] <= 1'b0;
                    // Chained block starts with no software action
                    if (ctrl_q[cur_q][dma_pkg::C_CHAIN]
                        && loaded_q[next_q[cur_q]]) begin
                        active_q[next_q[cur_q]] <= 1'b1;
                    end
                end
            end
            // Loads into a running channel are dropped
            if (cb_wr_i && !active_q[cb_chan_i]) begin
                idx_q[cb_chan_i] <= cb_index_i;
                xmod_q[cb_chan_i] <= cb_xmod_i;
                ymod_q[cb_chan_i] <= cb_ymod_i;
                xlen_q[cb_chan_i] <= cb_xcount_i;
                xcnt_q[cb_chan_i] <= cb_xcount_i;
                ycnt_q[cb_chan_i] <= cb_ycount_i;
                ctrl_q[cb_chan_i] <= cb_ctrl_i;
                next_q[cb_chan_i] <= cb_next_i;
                loaded_q[cb_chan_i] <= 1'b1;
                // Zero length blocks never start on load
                active_q[cb_chan_i] <= cb_ctrl_i[dma_pkg::C_VALID]
                    && cb_xcount_i != '0;
            end
        end
    end

    // Engine sequencing
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q <= dma_pkg::S_IDLE;
            cur_q <= '0;
            beat_q <= '0;
        end else begin
            unique case (st_q)
                dma_pkg::S_IDLE: begin
                    if (boot_addr_q == '0 && boot_eprom_mode_i
                        && booting_o) begin
                        st_q <= dma_pkg::S_BOOT;
                    end else if (soc_en && pick_ok) begin
                        cur_q <= pick;
                        beat_q <= '0;
                        if (pick == '0 && ctrl_q[0][dma_pkg::C_FLYBY]) begin
                            st_q <= dma_pkg::S_FLY;
                        end else if (pick == '0
                            && ctrl_q[0][dma_pkg::C_EPROM]) begin
                            st_q <= dma_pkg::S_EP;
                        end else begin
                            st_q <= dma_pkg::S_XFER;
                        end
                    end
                end
                dma_pkg::S_XFER: begin
                    if (step) begin
                        beat_q <= beat_q + 1'b1;
                        // Link channels hold the grant for a whole quad
                        if (last || cur_q < CHW'(dma_pkg::LNK_FIRST)
                            || cur_q > CHW'(dma_pkg::LNK_LAST)
                            || beat_q == 2'(dma_pkg::QUAD - 1)) begin
                            st_q <= dma_pkg::S_IDLE;
                        end
                    end
                end
                dma_pkg::S_FLY: begin
                    if (step && last) begin
                        st_q <= dma_pkg::S_IDLE;
                    end
                end
                dma_pkg::S_EP: begin
                    if (step && last) begin
                        st_q <= dma_pkg::S_IDLE;
                    end
                end
                dma_pkg::S_BOOT: begin
                    if (ep_sample && fifo_in_ready && ep_push
                        && boot_addr_q == BOOT_LAST) begin
                        st_q <= dma_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // Byte reads: fixed wait, then pack into words
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wait_q <= '0;
            byte_q <= '0;
            pack_q <= '0;
            boot_addr_q <= '0;
            booting_o <= 1'b1;
        end else begin
            if (st_q == dma_pkg::S_IDLE && !boot_eprom_mode_i) begin
                booting_o <= 1'b0;
            end
            if (ep_path && !ep_sample) begin
                wait_q <= wait_q + 1'b1;
            end else if (ep_sample && (fifo_in_ready || !ep_push)) begin
                wait_q <= '0;
                pack_q <= {eprom_byte_i, pack_q[23:8]};
                byte_q <= ep_push ? 2'b00 : byte_q + 1'b1;
                if (st_q == dma_pkg::S_BOOT) begin
                    boot_addr_q <= boot_addr_q + 1'b1;
                    if (boot_addr_q == BOOT_LAST) begin
                        booting_o <= 1'b0;
                    end
                end
            end
        end
    end

    // Byte space address and chip select
    always_comb begin
        eprom_addr_o = idx_q[0][dma_pkg::EP_AW-1:0];
        if (st_q == dma_pkg::S_BOOT) begin
            eprom_addr_o = boot_addr_q;
        end
        boot_eprom_select_n_o = ~ep_path;
    end

    // Buffer feed: packed bytes on the byte path, else source stream
    assign fifo_in_valid = ep_path ? ep_push : src_valid_i;
    assign fifo_in_data = ep_path ? pack_word : src_data_i;
    assign src_ready_o = fifo_in_ready & ~ep_path;

    dma_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(fifo_in_data),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .out_data_o(dst_data_o),
        .out_valid_o(dst_valid_o),
        .out_ready_i(dst_ready_i)
    );

    // Transfer announcements and completion pulses
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            xfer_valid_o <= 1'b0;
            xfer_chan_o <= '0;
            xfer_addr_o <= '0;
            xfer_last_o <= 1'b0;
            chan_done_o <= '0;
        end else begin
            xfer_valid_o <= step && st_q == dma_pkg::S_XFER;
            xfer_chan_o <= cur_q;
            xfer_addr_o <= idx_q[cur_q];
            xfer_last_o <= step && last;
            chan_done_o <= '0;
            if (step && last) begin
                chan_done_o[cur_q] <= 1'b1;
            end
        end
    end
    assign chan_busy_o = active_q;

    // Flyby: data bus released, device strobes held until the last word is acknowledged
    always_comb begin
        ext_addr_o = idx_q[0];
        ext_data_oe_o = 1'b0;
        sdram_bank_selects_n_o = 4'hF;
        io_read_strobe_n_o = 1'b1;
        io_write_strobe_n_o = 1'b1;
        io_transceiver_enable_n_o = 1'b1;
        rd_wr_n_o = 1'b1;
        if (st_q == dma_pkg::S_FLY) begin
            sdram_bank_selects_n_o = ~(4'h1 <<
                idx_q[0][dma_pkg::BANK_LSB +: dma_pkg::BANK_W]);
            io_read_strobe_n_o = 1'b0;
            io_transceiver_enable_n_o = 1'b0;
            rd_wr_n_o = 1'b0;
        end
    end
endmodule

/* hw/dma_pkg.sv */
// Purpose: Shared constants for the multichannel DMA engine.
// Assumes: One 50 MHz clock; shared widths and counts named here, data width, buffer depth and boot size are engine parameters.
// Notes: Channel groups sit at fixed indices in the channel array.
package dma_pkg;
    localparam int NCH = 14;           // Total channels
    localparam int CHW = 4;            // Channel number width
    localparam int EXT_LAST = 3;       // Channels 0..3: external port
    localparam int LRX_FIRST = 8;      // Channels 8..11: link receive
    localparam int LRX_N = 4;          // Link receive group size
    localparam int LNK_FIRST = 4;      // Channels 4..11: link ports
    localparam int LNK_LAST = 11;
    localparam int QUAD = 4;           // Words per link unit
    localparam int CTRL_W = 8;         // Control field width
    localparam int C_VALID = 0;        // Start on load
    localparam int C_2D = 1;           // Two-dimensional mode
    localparam int C_CHAIN = 2;        // Start next block when done
    localparam int C_MASTER = 3;       // Master mode (external channels)
    localparam int C_FLYBY = 4;        // Flyby (channel 0 only)
    localparam int C_EPROM = 5;        // Byte space access (channel 0)
    localparam int EP_AW = 24;         // Byte space address bits
    localparam int EP_WAIT = 16;       // Wait cycles per byte read
    localparam int BYTES_W = 4;        // Bytes packed per word
    localparam int SOC_DIV = 2;        // On-chip bus rate divider
    localparam int BANK_LSB = 26;      // SDRAM bank select field
    localparam int BANK_W = 2;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    typedef enum logic [2:0] {
        S_BOOT, S_IDLE, S_XFER, S_FLY, S_EP
    } eng_state_e;
endpackage

/* hw/dma_fifo.sv */
// Purpose: Data buffer between source and destination sides.
// Assumes: Single clock; DEPTH is a power of two.
// Notes: Full and empty are exact; drain side may stall.
`timescale 1ns/1ps
module dma_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];     // Storage array
    logic [AW:0] wr_q;                 // Write pointer with wrap bit
    logic [AW:0] rd_q;                 // Read pointer with wrap bit
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready_o = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_q != rd_q;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_q[AW-1:0]];

    // Storage write, no reset needed for data
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    // Pointer update
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

/* hw/dma_rr_arbiter.sv */
// Purpose: Rotating priority pick among N requesters.
// Assumes: Pointer moves only when a grant is used.
// Notes: Grant is combinational; one-hot or zero.
`timescale 1ns/1ps
module dma_rr_arbiter #(
    parameter int N = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [N-1:0] req_i,
    input wire logic advance_i,
    output logic [N-1:0] grant_o
);
    logic [N-1:0] prio_q;              // One-hot: highest priority slot

    // Scan from the priority slot around the ring
    always_comb begin
        logic seen;
        logic found;
        seen = 1'b0;
        found = 1'b0;
        grant_o = '0;
        for (int k = 0; k < 2 * N; k++) begin
            seen = seen | prio_q[k % N];
            if (seen && !found && req_i[k % N]) begin
                grant_o[k % N] = 1'b1;
                found = 1'b1;
            end
        end
    end

    // Winner moves to lowest priority so no slot is favoured for good
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prio_q <= {{(N-1){1'b0}}, 1'b1};
        end else if (advance_i && grant_o != '0) begin
            prio_q <= {grant_o[N-2:0], grant_o[N-1]};
        end
    end
endmodule

/* dv/dma_far_side.sv */
// Purpose: Far-side model: byte EPROM, SDRAM ack source, drain sink
// Assumes: Bytes are a fixed pattern of their address
// Notes: Deselected EPROM shows the inverse of its last byte
`timescale 1ns/1ps
module dma_far_side (
    input wire logic ref_clk_i,
    input wire logic [23:0] eprom_addr_i,
    input wire logic eprom_select_n_i,
    input wire logic io_read_strobe_n_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic [7:0] eprom_byte_o,
    output logic dst_ready_o,
    output logic ack_o
);
    logic [7:0] last_q = 8'h00; // Last byte driven
    logic [1:0] wait_q = 2'h0; // Slow-device wait counter
    // Last byte, inverted while deselected
    always_ff @(posedge ref_clk_i) begin
        if (!eprom_select_n_i) begin
            last_q <= eprom_addr_i[7:0] ^ 8'hA5;
        end
    end
    assign eprom_byte_o = eprom_select_n_i ? ~last_q : (eprom_addr_i[7:0] ^ 8'hA5);
    // Slow mode acks one cycle in four
    always_ff @(posedge ref_clk_i) begin
        wait_q <= io_read_strobe_n_i ? 2'h0 : wait_q + 2'h1;
    end
    assign ack_o = !io_read_strobe_n_i && (!slow_i || wait_q == 2'h3);
    assign dst_ready_o = !stall_i;
endmodule

/* dv/dma_engine_checker.sv */
// Purpose: Port checks for the DMA engine
// Assumes: One clock, sync active-low reset
// Notes: Bound from the bench top
`timescale 1ns/1ps
module dma_engine_checker (
    input wire logic ref_clk_i, rst_n_i, cb_wr_i, booting_o, xfer_valid_o, xfer_last_o,
    input wire logic [3:0] cb_chan_i, xfer_chan_o, sdram_bank_selects_n_o,
    input wire logic [7:0] cb_ctrl_i,
    input wire logic [15:0] cb_xcount_i,
    input wire logic [13:0] chan_busy_o, chan_done_o,
    input wire logic [23:0] eprom_addr_o,
    input wire logic boot_eprom_select_n_o, io_read_strobe_n_o, io_write_strobe_n_o,
    input wire logic io_transceiver_enable_n_o, rd_wr_n_o, ext_data_oe_o
);
    default clocking cb_main @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Start of a byte read
    sequence s_new_byte;
        !boot_eprom_select_n_o && ($fell(boot_eprom_select_n_o) || $changed(eprom_addr_o));
    endsequence
    a_bus_released: assert property (!ext_data_oe_o) else $error("bus driven");
    a_write_idle: assert property (io_write_strobe_n_o) else $error("write strobe");
    a_bank_onehot: assert property ($onehot0(~sdram_bank_selects_n_o)) else $error("banks");
    a_flyby_strobes: assert property (!io_read_strobe_n_o |->
        !io_transceiver_enable_n_o && !rd_wr_n_o) else $error("flyby strobes");
    a_byte_hold: assert property (s_new_byte |=>
        ($stable(eprom_addr_o) && !boot_eprom_select_n_o) [*8]) else $error("byte hold");
    a_select_owner: assert property (!boot_eprom_select_n_o |->
        booting_o || chan_busy_o[0]) else $error("select");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=>
        chan_busy_o == 14'h0 && booting_o && boot_eprom_select_n_o) else $error("reset");
    a_busy_load: assert property (cb_wr_i && !booting_o && cb_chan_i < 4'hE &&
        !chan_busy_o[cb_chan_i] && cb_ctrl_i[0] && cb_xcount_i != 16'h0
        |=> chan_busy_o[$past(cb_chan_i)]) else $error("load");
    a_chan_range: assert property (xfer_valid_o |-> xfer_chan_o < 4'hE) else $error("chan");
    a_last_done: assert property (xfer_valid_o && xfer_last_o |->
        chan_done_o[xfer_chan_o]) else $error("done");
endmodule

/* dv/multichannel_dma_with_eprom_boot_tb_top.sv */
// Purpose: Self-checking bench for the DMA engine
// Assumes: Boot load shortened to two words
// Notes: Far side is dma_far_side
`timescale 1ns/1ps
module multichannel_dma_with_eprom_boot_tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_n_i, boot_eprom_mode_i, cb_wr_i, src_valid_i, dst_ready_i, ack_i, xfer_valid_o;
    logic xfer_last_o, src_ready_o, dst_valid_o, boot_eprom_select_n_o, booting_o, stall, slow;
    logic io_read_strobe_n_o, io_write_strobe_n_o, io_transceiver_enable_n_o, rd_wr_n_o;
    logic ext_data_oe_o;
    logic [3:0] cb_chan_i, cb_next_i, xfer_chan_o, sdram_bank_selects_n_o;
    logic [7:0] cb_ctrl_i, eprom_byte_i;
    logic [15:0] cb_xcount_i, cb_ycount_i;
    logic [31:0] cb_index_i, cb_xmod_i, cb_ymod_i, xfer_addr_o, src_data_i, dst_data_o;
    logic [31:0] ext_addr_o;
    logic [13:0] chan_req_i, chan_busy_o, chan_done_o;
    logic [23:0] eprom_addr_o;
    logic [31:0] addr_q[$], word_q[$];
    logic [3:0] chan_q[$];
    int n_errors = 0, total_checks = 0, fly_n = 0;
    dma_engine #(.BOOT_WORDS(2)) dma_engine_inst (.*);
    dma_far_side dma_far_side_inst (.ref_clk_i(ref_clk_i), .eprom_addr_i(eprom_addr_o),
        .eprom_select_n_i(boot_eprom_select_n_o), .io_read_strobe_n_i(io_read_strobe_n_o),
        .stall_i(stall), .slow_i(slow), .eprom_byte_o(eprom_byte_i),
        .dst_ready_o(dst_ready_i), .ack_o(ack_i));
    always #10 ref_clk_i = ~ref_clk_i;
    // Log words, drained data, strobe cycles
    always @(posedge ref_clk_i) begin
        if (xfer_valid_o === 1'b1) begin
            addr_q.push_back(xfer_addr_o);
            chan_q.push_back(xfer_chan_o);
        end
        if (dst_valid_o === 1'b1 && dst_ready_i === 1'b1) word_q.push_back(dst_data_o);
        if (io_read_strobe_n_o === 1'b0) fly_n++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Expected boot word, little-endian
    function automatic logic [31:0] pack(input int k);
        for (int b = 0; b < 4; b++) pack[8*b +: 8] = 8'(4 * k + b) ^ 8'hA5;
    endfunction
    // Strobe drops between loads
    task automatic load(input logic [3:0] ch, input logic [31:0] idx, input logic [15:0] n,
                        input logic [7:0] ctl);
        cb_chan_i <= ch;
        cb_index_i <= idx;
        cb_xcount_i <= n;
        cb_ctrl_i <= ctl;
        cb_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        cb_wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic wait_idle(input int ch);
        for (int i = 0; i < 400 && chan_busy_o[ch] !== 1'b0; i++) @(posedge ref_clk_i);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, chan_busy_o[ch]}, 32'h0);
    endtask
    task automatic t_boot();
        int n;
        for (n = 0; n < 600 && booting_o !== 1'b0; n++) @(posedge ref_clk_i);
        repeat (4) @(posedge ref_clk_i);
        chk({31'h0, n >= 128}, 32'h1);
        chk(word_q.size(), 32'h2);
        for (int k = 0; k < 2; k++) chk(word_q[k], pack(k));
        boot_eprom_mode_i <= 1'b0;
    endtask
    // Second load hits a busy channel
    task automatic t_block();
        addr_q.delete();
        load(4'h1, 32'h100, 16'h3, 8'h09);
        load(4'h1, 32'h900, 16'h5, 8'h09);
        wait_idle(1);
        chk(addr_q.size(), 32'h3);
        for (int k = 0; k < 3; k++) chk(addr_q[k], 32'h100 + 4 * k);
    endtask
    task automatic t_link();
        chan_q.delete();
        load(4'h8, 32'h1000, 16'h8, 8'h01);
        load(4'h9, 32'h2000, 16'h8, 8'h01);
        wait_idle(8);
        wait_idle(9);
        chk(chan_q.size(), 32'h10);
        chk(chan_q[3], 32'h8);
        chk(chan_q[4], 32'h9);
    endtask
    task automatic t_flyby();
        fly_n = 0;
        slow <= 1'b1;
        load(4'h0, 32'h0C00_0000, 16'h2, 8'h11);
        wait_idle(0);
        chk({31'h0, fly_n >= 6}, 32'h1);
    endtask
    // Fill against a stalled drain, then empty
    task automatic t_fifo();
        int n;
        word_q.delete();
        stall <= 1'b1;
        src_data_i <= 32'hC000_0000;
        src_valid_i <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge ref_clk_i);
            if (src_ready_o !== 1'b1) break;
            @(posedge ref_clk_i);
            src_data_i <= 32'hC000_0001 + n;
        end
        @(posedge ref_clk_i);
        src_valid_i <= 1'b0;
        stall <= 1'b0;
        chk(n, 32'h10);
        for (int i = 0; i < 100 && word_q.size() < 16; i++) @(posedge ref_clk_i);
        for (int k = 0; k < 16; k++) chk(word_q[k], 32'hC000_0000 + k);
    endtask
    initial begin
        rst_n_i = 1'b0;
        boot_eprom_mode_i = 1'b1;
        {cb_wr_i, src_valid_i, stall, slow} = 4'h0;
        {cb_chan_i, cb_next_i, cb_ctrl_i, cb_xcount_i} = 32'h0;
        {cb_index_i, cb_ymod_i, src_data_i} = 96'h0;
        cb_xmod_i = 32'h4;
        cb_ycount_i = 16'h1;
        chan_req_i = 14'h3FFF;
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_boot();
        t_block();
        t_link();
        t_flyby();
        t_fifo();
        finish_test();
    end
    // Watchdog: tests need under 2000 cycles
    initial begin
        repeat (6000) @(posedge ref_clk_i);
        n_errors++;
        finish_test();
    end
endmodule
bind dma_engine dma_engine_checker dma_engine_checker_inst (.*);
